/* File: core/crf_pkg.sv */
package crf_pkg;

  localparam int DATA_W = 16;
  localparam int IDX_W = 4;
  localparam int NUM_REGS = 16;
  localparam int BYTE_W = 8;

  localparam logic [3:0] REG_INDEX_ZERO = 4'h0;
  localparam logic [3:0] REG_INDEX_ONE = 4'h1;
  localparam logic [3:0] STATUS_WORD_INDEX = 4'h2;
  localparam logic [3:0] FIRST_WORKING_REGISTER = 4'h4;
  localparam logic [3:0] LAST_WORKING_REGISTER = 4'hF;

  localparam logic [15:0] PROG_RESET = 16'h0000;
  localparam logic [15:0] STACK_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] WORD_BYTES = 16'h0002;
  localparam logic [7:0] HIGH_BYTE_CLEAR = 8'h00;

  typedef enum logic [4:0] {
    OP_NONE  = 5'b00001,
    OP_WRITE = 5'b00010,
    OP_PUSH  = 5'b00100,
    OP_POP   = 5'b01000,
    OP_IRQ   = 5'b10000
  } crf_op_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_IRQ_SW = 2'b10
  } crf_state_type;

  typedef struct packed {
    crf_op_type op;
    logic [3:0] idx;
    logic [15:0] data;
    logic byte_op;
    logic adv_en;
    logic [2:0] adv_len;
  } crf_cmd_type;

  typedef struct packed {
    logic [3:0] idx;
    logic byte_op;
  } crf_rd_type;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
  } crf_mem_type;

endpackage

/* File: core/crf_regfile.sv */
`timescale 1ns/1ps
// Function
// [RULE1] Sixteen 16-bit registers selected by a four-bit index.
// [RULE2] Index 0 program counter, 1 stack pointer, 4..15 working registers.
// [RULE3] Program counter advances by instruction length: two, four or six.
// [RULE4] Program counter stores bits 15..1; bit 0 always zero.
// [RULE5] Any write into the program counter acts as a branch.
// [RULE6] Stack pointer predecrements on push, postincrements on pop.
// [RULE7] Stack pointer stores bits 15..1; bit 0 forced zero.
// [RULE8] Software loads stack pointer; every op may read or write it.
// [RULE9] Pushing the stack pointer still decrements it.
// [RULE10] Popping into the stack pointer loads word, skips postincrement.
// [RULE11] Full 16-bit address bus, no paging or bank registers.
// [RULE12] Register-to-register operations complete in one clock cycle.
// [RULE13] Word and byte accesses to the register file supported.
// [RULE14] Interrupt entry pushes program counter then status word.
// [RULE15] Bit 0 writes to program counter or stack pointer ignored.
module crf_regfile
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sequencer command
  input wire crf_cmd_type cmd_i,
  output logic ready_o,
  // Read ports
  input wire crf_rd_type rd_a_i,
  input wire crf_rd_type rd_b_i,
  output logic [15:0] rd_a_data_o,
  output logic [15:0] rd_b_data_o,
  // Core state
  output logic [15:0] program_counter_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] status_word_o,
  // Stack writes to memory
  output crf_mem_type mem_o
);

  crf_state_type state_r, state_nxt;
  logic [15:1] program_counter_r, program_counter_nxt;
  logic [15:1] stack_pointer_r, stack_pointer_nxt;
  logic [15:0] gen_r [2:NUM_REGS-1];
  logic [15:0] file_view [NUM_REGS];
  crf_mem_type mem_r, mem_nxt;
  logic accept;
  logic wr_en;
  logic [15:0] wr_val;
  logic do_push;
  logic pop_inc;

  assign accept = (state_r == ST_IDLE);
  assign ready_o = accept;

  // Register writes from a plain write or a pop
  always_comb
  begin
    wr_en = accept && ((cmd_i.op == OP_WRITE) || (cmd_i.op == OP_POP));
    // Byte writes clear the high byte of the target
    wr_val = cmd_i.byte_op ? {HIGH_BYTE_CLEAR, cmd_i.data[7:0]}
                           : cmd_i.data; // [RULE13]
  end

  // Entries 0 and 1 live in the narrow counters below
  generate
    for (genvar i = 2; i < NUM_REGS; i++)
    begin : g_gen
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          gen_r[i] <= REG_RESET;
        else if (wr_en && (cmd_i.idx == 4'(i)))
          gen_r[i] <= wr_val; // [RULE12]
      end
    end
  endgenerate

  always_comb
  begin
    for (int k = 2; k < NUM_REGS; k++)
      file_view[k] = gen_r[k]; // [RULE1]
    file_view[REG_INDEX_ZERO] = {program_counter_r, 1'b0}; // [RULE2] [RULE4]
    file_view[REG_INDEX_ONE] = {stack_pointer_r, 1'b0}; // [RULE2] [RULE7]
  end

  always_comb
  begin
    rd_a_data_o = file_view[rd_a_i.idx];
    if (rd_a_i.byte_op)
      rd_a_data_o[15:8] = HIGH_BYTE_CLEAR; // [RULE13]
    rd_b_data_o = file_view[rd_b_i.idx];
    if (rd_b_i.byte_op)
      rd_b_data_o[15:8] = HIGH_BYTE_CLEAR; // [RULE13]
  end

  // Program counter: a write is a branch and beats the advance
  always_comb
  begin
    program_counter_nxt = program_counter_r;
    if (accept && cmd_i.adv_en && (cmd_i.op != OP_IRQ))
      program_counter_nxt = program_counter_r
                            + 15'(cmd_i.adv_len[2:1]); // [RULE3]
    if (wr_en && (cmd_i.idx == REG_INDEX_ZERO))
      program_counter_nxt = wr_val[15:1]; // [RULE5] [RULE15]
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      program_counter_r <= PROG_RESET[15:1];
    else
      program_counter_r <= program_counter_nxt; // [RULE4]
  end

  // Interrupt entry takes two cycles, one push each
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (cmd_i.op == OP_IRQ)
          state_nxt = ST_IRQ_SW; // [RULE14]
      ST_IRQ_SW:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  assign do_push = (accept && ((cmd_i.op == OP_PUSH) ||
                    (cmd_i.op == OP_IRQ))) || (state_r == ST_IRQ_SW);
  assign pop_inc = accept && (cmd_i.op == OP_POP) &&
                   (cmd_i.idx != REG_INDEX_ONE);

  // Stack pointer; a pop into it replaces the increment
  always_comb
  begin
    stack_pointer_nxt = stack_pointer_r;
    if (do_push)
      stack_pointer_nxt = stack_pointer_r - 15'd1; // [RULE6] [RULE9]
    else if (pop_inc)
      stack_pointer_nxt = stack_pointer_r + 15'd1; // [RULE6]
    if (wr_en && (cmd_i.idx == REG_INDEX_ONE))
      stack_pointer_nxt = wr_val[15:1]; // [RULE8] [RULE10] [RULE15]
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stack_pointer_r <= STACK_RESET[15:1];
    else
      stack_pointer_r <= stack_pointer_nxt; // [RULE7]
  end

  // Push goes to the decremented address; pushing the stack pointer
  // stores whatever value the sequencer read before the decrement
  always_comb
  begin
    mem_nxt.wr = do_push;
    mem_nxt.addr = {stack_pointer_r - 15'd1, 1'b0}; // [RULE11]
    mem_nxt.data = cmd_i.data;
    if (state_r == ST_IRQ_SW)
      mem_nxt.data = file_view[STATUS_WORD_INDEX]; // [RULE14]
    else if (cmd_i.op == OP_IRQ)
      mem_nxt.data = {program_counter_r, 1'b0}; // [RULE14]
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mem_r <= '0;
    else
      mem_r <= mem_nxt;
  end

  assign mem_o = mem_r;
  assign program_counter_o = file_view[REG_INDEX_ZERO];
  assign stack_pointer_o = file_view[REG_INDEX_ONE];
  assign status_word_o = file_view[STATUS_WORD_INDEX];

  // Checks
  logic [15:0] wr_word_mask;
  assign wr_word_mask = 16'hFFFE;

  property p_push_dec;
    @(posedge clk) disable iff (!resetn)
    (accept && cmd_i.op == OP_PUSH) |=>
      (stack_pointer_o == $past(stack_pointer_o) - WORD_BYTES)
      && mem_o.wr && (mem_o.addr == stack_pointer_o);
  endproperty
  a_push_dec: assert property (p_push_dec) // [RULE6] [RULE9]
    else $error("push did not predecrement stack pointer");

  property p_pop_inc;
    @(posedge clk) disable iff (!resetn)
    (accept && cmd_i.op == OP_POP && cmd_i.idx != REG_INDEX_ONE) |=>
      stack_pointer_o == $past(stack_pointer_o) + WORD_BYTES;
  endproperty
  a_pop_inc: assert property (p_pop_inc) // [RULE6]
    else $error("pop did not postincrement stack pointer");

  property p_pop_self;
    @(posedge clk) disable iff (!resetn)
    (accept && cmd_i.op == OP_POP && cmd_i.idx == REG_INDEX_ONE &&
     !cmd_i.byte_op) |=>
      stack_pointer_o == ($past(cmd_i.data) & wr_word_mask);
  endproperty
  a_pop_self: assert property (p_pop_self) // [RULE10]
    else $error("pop into stack pointer not loaded as popped");

  property p_advance;
    @(posedge clk) disable iff (!resetn)
    (accept && cmd_i.adv_en && cmd_i.op == OP_NONE) |=>
      program_counter_o == $past(program_counter_o)
                           + {13'h0000, $past(cmd_i.adv_len[2:1]), 1'b0};
  endproperty
  a_advance: assert property (p_advance) // [RULE3]
    else $error("program counter advanced by wrong length");

  property p_branch;
    @(posedge clk) disable iff (!resetn)
    (wr_en && cmd_i.idx == REG_INDEX_ZERO && !cmd_i.byte_op) |=>
      program_counter_o == ($past(cmd_i.data) & wr_word_mask);
  endproperty
  a_branch: assert property (p_branch) // [RULE5] [RULE15]
    else $error("program counter write did not branch");

  property p_aligned;
    @(posedge clk) disable iff (!resetn)
    !program_counter_o[0] && !stack_pointer_o[0] && !mem_o.addr[0];
  endproperty
  a_aligned: assert property (p_aligned) // [RULE4] [RULE7]
    else $error("odd program counter or stack address");

  property p_work_write;
    @(posedge clk) disable iff (!resetn)
    (wr_en && cmd_i.idx >= FIRST_WORKING_REGISTER) |=>
      file_view[$past(cmd_i.idx)] ==
        ($past(cmd_i.byte_op) ? {HIGH_BYTE_CLEAR, $past(cmd_i.data[7:0])}
                              : $past(cmd_i.data));
  endproperty
  a_work_write: assert property (p_work_write) // [RULE12] [RULE13]
    else $error("working register write not done in one cycle");

  sequence s_push_return;
    mem_o.wr && !ready_o &&
    (mem_o.data == {$past(program_counter_r), 1'b0});
  endsequence

  sequence s_push_status;
    mem_o.wr && ready_o &&
    (mem_o.addr == $past(mem_o.addr) - WORD_BYTES) &&
    (mem_o.data == $past(status_word_o));
  endsequence

  property p_irq_entry;
    @(posedge clk) disable iff (!resetn)
    (accept && cmd_i.op == OP_IRQ) |=> s_push_return ##1 s_push_status;
  endproperty
  a_irq_entry: assert property (p_irq_entry) // [RULE14]
    else $error("interrupt entry push order wrong");

  // A command offered while entry is busy must leave the file alone
  property p_refused;
    @(posedge clk) disable iff (!resetn)
    (!ready_o && cmd_i.idx != REG_INDEX_ONE) |=>
      file_view[$past(cmd_i.idx)] == $past(file_view[cmd_i.idx]);
  endproperty
  a_refused: assert property (p_refused) // [RULE14]
    else $error("command taken during interrupt entry");

  property p_sp_load;
    @(posedge clk) disable iff (!resetn)
    (ready_o && cmd_i.op == OP_WRITE && cmd_i.idx == REG_INDEX_ONE &&
     !cmd_i.byte_op) |=>
      stack_pointer_o == ($past(cmd_i.data) & wr_word_mask);
  endproperty
  a_sp_load: assert property (p_sp_load) // [RULE8] [RULE15]
    else $error("stack pointer write not loaded");

  // A stack write must trace back to a push, never to a plain write
  property p_push_source;
    @(posedge clk) disable iff (!resetn)
    mem_o.wr |->
      !$past(ready_o) ||
      ($past(cmd_i.op) == OP_PUSH) || ($past(cmd_i.op) == OP_IRQ);
  endproperty
  a_push_source: assert property (p_push_source) // [RULE6] [RULE11]
    else $error("stack write without a push");

  // Without advance or branch the program counter must hold
  property p_pc_hold;
    @(posedge clk) disable iff (!resetn)
    (!(ready_o && cmd_i.adv_en && cmd_i.op != OP_IRQ) &&
     !(ready_o && cmd_i.idx == REG_INDEX_ZERO &&
       (cmd_i.op == OP_WRITE || cmd_i.op == OP_POP))) |=>
      program_counter_o == $past(program_counter_o);
  endproperty
  a_pc_hold: assert property (p_pc_hold) // [RULE3] [RULE5]
    else $error("program counter moved without cause");

endmodule

/* File: tb/crf_mem_model.sv */
`timescale 1ns/1ps
// Word memory standing in for the stack RAM behind the core
module crf_mem_model
  import crf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus from the core
  input wire crf_mem_type mem_i,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [0:255];

  // Word address only, low bit never reaches the array
  always_ff @(posedge clk)
  begin
    if (mem_i.wr)
      mem[mem_i.addr[8:1]] <= mem_i.data;
  end

  assign rd_data = mem[rd_addr[8:1]];
endmodule

/* File: tb/test_crf_regfile.sv */
`timescale 1ns/1ps
module test_crf_regfile
  import crf_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  crf_cmd_type cmd_i = '{OP_NONE, 4'h0, 16'h0000, 1'b0, 1'b0, 3'h0};
  crf_rd_type rd_a_i = '{4'h0, 1'b0};
  crf_rd_type rd_b_i = '{4'h0, 1'b0};
  logic ready_o;
  logic [15:0] rd_a_data_o, rd_b_data_o, pc, sp, sw, top_word;
  crf_mem_type mem_o;
  int fail_count = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  crf_regfile u_dut (.clk(clk), .resetn(resetn), .cmd_i(cmd_i),
    .ready_o(ready_o), .rd_a_i(rd_a_i), .rd_b_i(rd_b_i),
    .rd_a_data_o(rd_a_data_o), .rd_b_data_o(rd_b_data_o),
    .program_counter_o(pc), .stack_pointer_o(sp), .status_word_o(sw),
    .mem_o(mem_o));

  crf_mem_model u_mem (.clk(clk), .mem_i(mem_o), .rd_addr(sp),
    .rd_data(top_word));

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Present for one edge, then idle; results sampled just after it
  task automatic go(crf_op_type op, logic [3:0] idx, logic [15:0] d,
                    logic b = 1'b0, logic ae = 1'b0, logic [2:0] al = 3'h0);
    @(posedge clk);
    cmd_i <= '{op, idx, d, b, ae, al};
    @(posedge clk);
    cmd_i <= '{OP_NONE, 4'h0, 16'h0000, 1'b0, 1'b0, 3'h0};
    #1;
  endtask

  // Set both read ports on an edge and let the mux settle
  task automatic peek(logic [3:0] ia, logic ba, logic [3:0] ib, logic bb);
    @(posedge clk);
    rd_a_i <= '{ia, ba};
    rd_b_i <= '{ib, bb};
    #1;
  endtask

  task automatic t_reset();
    check("pc", pc, 16'h0000);
    check("sp", sp, 16'h0000);
    check("rdy", {15'h0000, ready_o}, 16'h0001);
  endtask

  task automatic t_regs();
    go(OP_WRITE, 4'h4, 16'hA5C3);
    go(OP_WRITE, 4'hF, 16'h1234);
    go(OP_WRITE, 4'h6, 16'hBEEF, 1'b1);
    peek(4'hF, 1'b0, 4'h4, 1'b1);
    check("last_work", rd_a_data_o, 16'h1234);
    check("first_work_b", rd_b_data_o, 16'h00C3);
    peek(4'h6, 1'b0, 4'h4, 1'b0);
    check("work6", rd_a_data_o, 16'h00EF);
    check("first_work", rd_b_data_o, 16'hA5C3);
  endtask

  task automatic t_pc();
    go(OP_WRITE, 4'h0, 16'h1235);
    check("br", pc, 16'h1234);
    go(OP_NONE, 4'h0, 16'h0000, 1'b0, 1'b1, 3'h2);
    check("adv2", pc, 16'h1236);
    go(OP_NONE, 4'h0, 16'h0000, 1'b0, 1'b1, 3'h4);
    check("adv4", pc, 16'h123A);
    go(OP_NONE, 4'h0, 16'h0000, 1'b0, 1'b1, 3'h6);
    check("adv6", pc, 16'h1240);
  endtask

  task automatic t_stack();
    go(OP_WRITE, 4'h1, 16'h0201);
    check("spw", sp, 16'h0200);
    go(OP_PUSH, 4'h9, 16'hCAFE);
    check("sp-", sp, 16'h01FE);
    check("wr", {15'h0000, mem_o.wr}, 16'h0001);
    check("wa", mem_o.addr, 16'h01FE);
    check("wd", mem_o.data, 16'hCAFE);
    // The stack RAM takes the word one edge after the pulse
    @(posedge clk);
    #1;
    check("ram", top_word, 16'hCAFE);
    go(OP_POP, 4'h7, top_word);
    check("sp+", sp, 16'h0200);
    peek(4'h7, 1'b0, 4'h7, 1'b1);
    check("pop", rd_a_data_o, 16'hCAFE);
    check("popb", rd_b_data_o, 16'h00FE);
    go(OP_PUSH, 4'h1, sp);
    check("psp", sp, 16'h01FE);
    check("pspd", mem_o.data, 16'h0200);
    go(OP_PUSH, 4'h8, 16'h0301);
    @(posedge clk);
    #1;
    go(OP_POP, 4'h1, top_word);
    check("popsp", sp, 16'h0300);
  endtask

  task automatic t_irq();
    go(OP_WRITE, 4'h2, 16'h0008);
    check("sw", sw, 16'h0008);
    go(OP_WRITE, 4'h0, 16'h4000);
    @(posedge clk);
    cmd_i <= '{OP_IRQ, 4'h0, 16'h0000, 1'b0, 1'b1, 3'h2};
    @(posedge clk);
    // Offered in the busy cycle, so it must be dropped
    cmd_i <= '{OP_WRITE, 4'h5, 16'h1111, 1'b0, 1'b1, 3'h2};
    #1;
    check("busy", {15'h0000, ready_o}, 16'h0000);
    check("ia1", mem_o.addr, 16'h02FE);
    check("id1", mem_o.data, 16'h4000);
    check("ipc1", pc, 16'h4000);
    @(posedge clk);
    cmd_i <= '{OP_NONE, 4'h0, 16'h0000, 1'b0, 1'b0, 3'h0};
    #1;
    check("rdy2", {15'h0000, ready_o}, 16'h0001);
    check("ia2", mem_o.addr, 16'h02FC);
    check("id2", mem_o.data, 16'h0008);
    check("isp", sp, 16'h02FC);
    check("ipc2", pc, 16'h4000);
    @(posedge clk);
    #1;
    check("top", top_word, 16'h0008);
    peek(4'h5, 1'b0, 4'h2, 1'b0);
    check("work5", rd_a_data_o, 16'h0000);
    check("sw2", rd_b_data_o, 16'h0008);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_regs();
    t_pc();
    t_stack();
    t_irq();
    report_and_stop();
  end

  // Run needs well under 100 cycles
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop();
  end
endmodule
